// *** logic/ocr_pkg.sv ***
// constants shared by the overcurrent output routing block
// assumes a classic wishbone bus with 32-bit data and byte addresses
package ocr_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OCR_ROUTE_OFS = 8'h00;
	localparam logic [7:0] OCR_OPTION_OFS = 8'h04;
	localparam logic [7:0] OCR_DISPLAY_OFS = 8'h08;
	localparam logic [7:0] OCR_IRQ_STATUS_OFS = 8'h0c;
	localparam logic [7:0] OCR_IRQ_MASK_OFS = 8'h10;
	localparam logic [7:0] OCR_LIVE_OFS = 8'h14;
	localparam logic [7:0] OCR_FAULT_CODE_OFS = 8'h18;

	// ------------------------------------------------------------
	// field widths and reset values
	// ------------------------------------------------------------
	localparam int OCR_ROUTE_W = 8;
	localparam int OCR_DISP_W = 4;
	localparam int OCR_EVENT_W = 5;
	localparam int OCR_CODE_W = 8;
	localparam int OCR_VALUE_W = 16;
	localparam int OCR_LIVE_W = 12;
	localparam logic [7:0] OCR_ROUTE_RST = 8'hff;
	localparam logic OCR_LATCH_RST = 1'b0;
	localparam logic [3:0] OCR_DISP_RST = 4'h0;
	localparam logic [4:0] OCR_MASK_RST = 5'h00;

	// ------------------------------------------------------------
	// routing switch positions (position n sits at bit n-1)
	// ------------------------------------------------------------
	localparam int OCR_SW_BLOCK = 0;
	localparam int OCR_SW_HS_START_D = 1;
	localparam int OCR_SW_LS_START_D = 2;
	localparam int OCR_SW_HS_TRIP_D = 3;
	localparam int OCR_SW_HS_TRIP_C = 4;
	localparam int OCR_SW_HS_TRIP_A = 5;
	localparam int OCR_SW_LS_TRIP_C = 6;
	localparam int OCR_SW_LS_TRIP_B = 7;

	// ------------------------------------------------------------
	// option and event bit positions
	// ------------------------------------------------------------
	localparam int OCR_OPT_LATCH = 0;
	localparam int OCR_EV_LS_START = 0;
	localparam int OCR_EV_LS_TRIP = 1;
	localparam int OCR_EV_HS_START = 2;
	localparam int OCR_EV_HS_TRIP = 3;
	localparam int OCR_EV_FAULT = 4;

	// ------------------------------------------------------------
	// display item codes
	// ------------------------------------------------------------
	localparam logic [3:0] OCR_DISP_NONE = 4'h0;
	localparam logic [3:0] OCR_DISP_PHASE1 = 4'h1;
	localparam logic [3:0] OCR_DISP_PHASE2 = 4'h2;
	localparam logic [3:0] OCR_DISP_PHASE3 = 4'h3;
	localparam logic [3:0] OCR_DISP_KNOB0 = 4'h4;
	localparam logic [3:0] OCR_DISP_CHECKSUM = 4'hc;

endpackage : ocr_pkg

// *** logic/ocr_rst_sync.sv ***
// reset release synchroniser for the routing block
// assumes nrst may drop at any time; release is taken on clk
`timescale 1ns/100ps
module ocr_rst_sync (
	// clock and raw reset
	input logic clk,
	input logic nrst,
	// synchronised reset, active low
	output logic rst_n
);

	logic meta_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			meta_reg <= 1'b1;
			rst_n <= meta_reg;
		end
	end

endmodule : ocr_rst_sync

// *** logic/ocr_stage_hold.sv ***
// start and trip holding for one overcurrent stage
// assumes start and trip are synchronous to clk; outputs are combinational
`timescale 1ns/100ps
module ocr_stage_hold (
	// clock and reset
	input logic clk,
	input logic rst_n,
	// live stage signals
	input logic start_in,
	input logic trip_in,
	// latch option and reset pushbutton
	input logic latch_en,
	input logic clear_press,
	// effective signals and indicator colour
	output logic start_eff,
	output logic trip_eff,
	output logic yellow,
	output logic red
);

	logic start_held_reg;
	logic trip_held_reg;

	// a live signal wins over the pushbutton so no start is lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_held_reg <= 1'b0;
			trip_held_reg <= 1'b0;
		end else begin
			start_held_reg <= latch_en & (start_in | (start_held_reg & ~clear_press));
			trip_held_reg <= latch_en & (trip_in | (trip_held_reg & ~clear_press));
		end
	end

	// held state only extends outputs, never masks a live signal
	assign start_eff = start_in | start_held_reg;
	assign trip_eff = trip_in | trip_held_reg;
	assign red = trip_eff;
	assign yellow = start_eff & ~trip_eff;

endmodule : ocr_stage_hold

// *** logic/ocr_routing.sv ***
// overcurrent output routing, indicators and wishbone register file
// assumes stage, fault and front-panel inputs are synchronous to clk
`timescale 1ns/100ps
module ocr_routing
	import ocr_pkg::*;
#(
	parameter int KNOBS = 4
) (
	// clock and reset
	input logic clk,
	input logic nrst,
	// wishbone slave
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// measuring module signals
	input logic low_start,
	input logic low_trip,
	input logic high_start,
	input logic high_trip,
	output logic block_to_module,
	// self-supervision
	input logic fault_detect,
	input logic [7:0] fault_code_in,
	// front panel inputs
	input logic external_block_input,
	input logic reset_button,
	input logic [7:0] characteristic_switches,
	// output relays
	output logic relay_a,
	output logic relay_b,
	output logic relay_c,
	output logic relay_d,
	output logic relay_e,
	// stage indicators
	output logic low_yellow,
	output logic low_red,
	output logic high_yellow,
	output logic high_red,
	// display and lamps
	output logic phase_one_select_lamp,
	output logic phase_two_select_lamp,
	output logic phase_three_select_lamp,
	output logic [KNOBS-1:0] knob_lamp,
	output logic characteristic_lamp,
	output logic internal_fault_indicator,
	output logic [15:0] display_value,
	// interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// knob codes must stay clear of the checksum code
	if (KNOBS < 1 || KNOBS > 8) begin : g_bad_knobs
		$error("KNOBS must be between 1 and 8");
	end

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_n;

	ocr_rst_sync u_rst (
		.clk(clk),
		.nrst(nrst),
		.rst_n(rst_n)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] apply_sel(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] sel);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = new_val[8*i +: 8];
			end
		end
		return res;
	endfunction : apply_sel

	function automatic logic rise(input logic now_val, input logic old_val);
		return now_val & ~old_val;
	endfunction : rise

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [OCR_ROUTE_W-1:0] route_reg;
	logic latch_reg;
	logic [OCR_DISP_W-1:0] disp_reg;
	logic [OCR_EVENT_W-1:0] irq_status_reg;
	logic [OCR_EVENT_W-1:0] irq_mask_reg;
	logic [OCR_CODE_W-1:0] fault_code_reg;
	logic fault_held_reg;
	logic [OCR_EVENT_W-1:0] event_prev_reg;
	logic reset_button_prev_reg;

	logic bus_req;
	logic bus_wr;
	logic [31:0] wr_merged;
	logic [31:0] rd_next;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_req & wb_we_i;

	// ------------------------------------------------------------
	// stage holding and indicators
	// ------------------------------------------------------------
	logic clear_press;
	logic ls_start_eff;
	logic ls_trip_eff;
	logic hs_start_eff;
	logic hs_trip_eff;
	logic ls_yellow;
	logic ls_red;
	logic hs_yellow;
	logic hs_red;

	// one press clears once, holding the button does not block new holds
	assign clear_press = rise(reset_button, reset_button_prev_reg);

	ocr_stage_hold u_low (
		.clk(clk),
		.rst_n(rst_n),
		.start_in(low_start),
		.trip_in(low_trip),
		.latch_en(latch_reg),
		.clear_press(clear_press),
		.start_eff(ls_start_eff),
		.trip_eff(ls_trip_eff),
		.yellow(ls_yellow),
		.red(ls_red)
	);

	ocr_stage_hold u_high (
		.clk(clk),
		.rst_n(rst_n),
		.start_in(high_start),
		.trip_in(high_trip),
		.latch_en(latch_reg),
		.clear_press(clear_press),
		.start_eff(hs_start_eff),
		.trip_eff(hs_trip_eff),
		.yellow(hs_yellow),
		.red(hs_red)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_yellow <= 1'b0;
			low_red <= 1'b0;
			high_yellow <= 1'b0;
			high_red <= 1'b0;
			reset_button_prev_reg <= 1'b0;
		end else begin
			low_yellow <= ls_yellow;
			low_red <= ls_red;
			high_yellow <= hs_yellow;
			high_red <= hs_red;
			reset_button_prev_reg <= reset_button;
		end
	end

	// ------------------------------------------------------------
	// output relays
	// ------------------------------------------------------------
	// relays use the effective signals so latching reaches them too
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			relay_a <= 1'b0;
			relay_b <= 1'b0;
			relay_c <= 1'b0;
			relay_d <= 1'b0;
			relay_e <= 1'b0;
			block_to_module <= 1'b0;
		end else begin
			relay_a <= ls_trip_eff | (route_reg[OCR_SW_HS_TRIP_A] & hs_trip_eff);
			relay_b <= hs_trip_eff | (route_reg[OCR_SW_LS_TRIP_B] & ls_trip_eff);
			relay_c <= (route_reg[OCR_SW_HS_TRIP_C] & hs_trip_eff)
				| (route_reg[OCR_SW_LS_TRIP_C] & ls_trip_eff);
			relay_d <= (route_reg[OCR_SW_HS_START_D] & hs_start_eff)
				| (route_reg[OCR_SW_LS_START_D] & ls_start_eff)
				| (route_reg[OCR_SW_HS_TRIP_D] & hs_trip_eff);
			relay_e <= fault_held_reg;
			block_to_module <= route_reg[OCR_SW_BLOCK] & external_block_input;
		end
	end

	// ------------------------------------------------------------
	// self-supervision
	// ------------------------------------------------------------
	// a permanent fault stays until the block is reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_held_reg <= 1'b0;
			fault_code_reg <= '0;
		end else if (fault_detect && !fault_held_reg) begin
			fault_held_reg <= 1'b1;
			fault_code_reg <= fault_code_in;
		end
	end

	// ------------------------------------------------------------
	// display and lamps
	// ------------------------------------------------------------
	logic [KNOBS-1:0] knob_next;

	always_comb begin
		knob_next = '0;
		for (int k = 0; k < KNOBS; k++) begin
			knob_next[k] = (disp_reg == OCR_DISP_KNOB0 + 4'(k));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_one_select_lamp <= 1'b0;
			phase_two_select_lamp <= 1'b0;
			phase_three_select_lamp <= 1'b0;
			knob_lamp <= '0;
			characteristic_lamp <= 1'b0;
			internal_fault_indicator <= 1'b0;
			display_value <= '0;
		end else begin
			phase_one_select_lamp <= (disp_reg == OCR_DISP_PHASE1);
			phase_two_select_lamp <= (disp_reg == OCR_DISP_PHASE2);
			phase_three_select_lamp <= (disp_reg == OCR_DISP_PHASE3);
			knob_lamp <= knob_next;
			characteristic_lamp <= (disp_reg == OCR_DISP_CHECKSUM);
			internal_fault_indicator <= fault_held_reg;
			// the fault code takes the display over any other item
			if (fault_held_reg) begin
				display_value <= {8'h00, fault_code_reg};
			end else if (disp_reg == OCR_DISP_CHECKSUM) begin
				display_value <= {8'h00, characteristic_switches};
			end else begin
				display_value <= 16'h0000;
			end
		end
	end

	// ------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------
	logic [OCR_EVENT_W-1:0] event_now;
	logic [OCR_EVENT_W-1:0] event_set;
	logic [OCR_EVENT_W-1:0] event_clr;

	assign event_now = {fault_held_reg, high_trip, high_start, low_trip, low_start};
	assign event_set = event_now & ~event_prev_reg;
	assign event_clr = (bus_wr && wb_adr_i == OCR_IRQ_STATUS_OFS && wb_sel_i[0])
		? wb_dat_i[OCR_EVENT_W-1:0] : '0;

	// set beats a same-cycle write-one-to-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			event_prev_reg <= '0;
			irq_status_reg <= '0;
			irq <= 1'b0;
		end else begin
			event_prev_reg <= event_now;
			irq_status_reg <= (irq_status_reg & ~event_clr) | event_set;
			irq <= |(((irq_status_reg & ~event_clr) | event_set) & irq_mask_reg);
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	assign wr_merged = apply_sel(32'h00000000, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			route_reg <= OCR_ROUTE_RST;
		end else if (bus_wr && wb_adr_i == OCR_ROUTE_OFS && wb_sel_i[0]) begin
			route_reg <= wr_merged[OCR_ROUTE_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= OCR_LATCH_RST;
		end else if (bus_wr && wb_adr_i == OCR_OPTION_OFS && wb_sel_i[0]) begin
			latch_reg <= wr_merged[OCR_OPT_LATCH];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_reg <= OCR_DISP_RST;
		end else if (bus_wr && wb_adr_i == OCR_DISPLAY_OFS && wb_sel_i[0]) begin
			disp_reg <= wr_merged[OCR_DISP_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_reg <= OCR_MASK_RST;
		end else if (bus_wr && wb_adr_i == OCR_IRQ_MASK_OFS && wb_sel_i[0]) begin
			irq_mask_reg <= wr_merged[OCR_EVENT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	always_comb begin
		rd_next = 32'h00000000;
		if (wb_adr_i == OCR_ROUTE_OFS) begin
			rd_next[OCR_ROUTE_W-1:0] = route_reg;
		end else if (wb_adr_i == OCR_OPTION_OFS) begin
			rd_next[OCR_OPT_LATCH] = latch_reg;
		end else if (wb_adr_i == OCR_DISPLAY_OFS) begin
			rd_next[OCR_DISP_W-1:0] = disp_reg;
		end else if (wb_adr_i == OCR_IRQ_STATUS_OFS) begin
			rd_next[OCR_EVENT_W-1:0] = irq_status_reg;
		end else if (wb_adr_i == OCR_IRQ_MASK_OFS) begin
			rd_next[OCR_EVENT_W-1:0] = irq_mask_reg;
		end else if (wb_adr_i == OCR_LIVE_OFS) begin
			rd_next[OCR_LIVE_W-1:0] = {relay_e, relay_d, relay_c, relay_b, relay_a,
				block_to_module, fault_held_reg, hs_trip_eff, hs_start_eff,
				ls_trip_eff, ls_start_eff, latch_reg};
		end else if (wb_adr_i == OCR_FAULT_CODE_OFS) begin
			rd_next[OCR_CODE_W-1:0] = fault_code_reg;
		end
	end

	// one wait state: ack one edge after the request appears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? rd_next : 32'h00000000;
		end
	end

endmodule : ocr_routing

// *** bench/ocr_routing_assertions.sv ***
// concurrent checks on the ports of the routing block
// assumes bind from the bench top; clk and nrst of the design
`timescale 1ns/100ps
module ocr_routing_assertions #(
	parameter int KNOBS = 4
) (
	// clock, reset and bus
	input logic clk,
	input logic nrst,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_ack_o,
	// stage and front panel
	input logic low_start,
	input logic low_trip,
	input logic high_trip,
	input logic external_block_input,
	input logic fault_detect,
	// outputs
	input logic block_to_module,
	input logic relay_a,
	input logic relay_b,
	input logic low_yellow,
	input logic low_red,
	input logic high_red,
	input logic internal_fault_indicator,
	input logic phase_one_select_lamp,
	input logic phase_two_select_lamp,
	input logic phase_three_select_lamp,
	input logic [KNOBS-1:0] knob_lamp,
	input logic characteristic_lamp
);
	// ------------------------------------------------------------
	// settle window
	// ------------------------------------------------------------
	// internal reset lifts two edges after nrst, so checks wait three
	logic [1:0] up_cnt;
	logic off;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			up_cnt <= 2'h0;
		end else if (up_cnt != 2'h3) begin
			up_cnt <= up_cnt + 2'h1;
		end
	end
	assign off = !nrst || (up_cnt != 2'h3);
	default clocking cb @(posedge clk); endclocking
	default disable iff (off);
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_relay_a_fixed: assert property (low_trip |=> relay_a)
		else $error("relay a missed low trip");
	a_relay_b_fixed: assert property (high_trip |=> relay_b)
		else $error("relay b missed high trip");
	a_block_pass: assert property (block_to_module |-> $past(external_block_input))
		else $error("block without external input");
	a_yellow_start: assert property ($rose(low_yellow) |-> $past(low_start))
		else $error("yellow without start");
	a_red_low_trip: assert property (low_trip |=> low_red)
		else $error("low red missed trip");
	a_red_high_trip: assert property (high_trip |=> high_red)
		else $error("high red missed trip");
	a_lamp_one_hot: assert property ($onehot0({phase_one_select_lamp, phase_two_select_lamp,
		phase_three_select_lamp, knob_lamp, characteristic_lamp}))
		else $error("more than one display lamp lit");
	// fault is held one edge after detect, the lamp registers one edge later
	a_fault_lit: assert property (fault_detect |-> ##2 internal_fault_indicator)
		else $error("fault indicator not lit after fault");
	a_fault_hold: assert property (internal_fault_indicator |=> internal_fault_indicator)
		else $error("fault indicator dropped");
	a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after one cycle");
	c_low_trip: cover property (low_trip ##1 relay_a);
	c_high_trip: cover property (high_trip ##1 relay_b);
	c_fault: cover property ($rose(internal_fault_indicator));
endmodule : ocr_routing_assertions

// *** bench/ocr_meas_model.sv ***
// behavioural overcurrent measuring module at the far side
// assumes commanded levels come from the bench, synchronous to clk
`timescale 1ns/100ps
module ocr_meas_model (
	// commanded levels {high_trip, high_start, low_trip, low_start}
	input logic [3:0] cmd,
	// blocking from the routing block
	input logic block_to_module,
	// stage signals
	output logic low_start,
	output logic low_trip,
	output logic high_start,
	output logic high_trip
);
	// a blocked module raises neither start nor trip
	assign {high_trip, high_start, low_trip, low_start} = block_to_module ? 4'h0 : cmd;
endmodule : ocr_meas_model

// *** bench/ocr_routing_bench.sv ***
// self-checking bench for the routing block
// assumes the package, the design and the measuring model are compiled first
`timescale 1ns/100ps
module ocr_routing_bench;
	import ocr_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00, sw = 8'h5a, code = 8'h3c;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [3:0] cmd = 4'h0, sel = 4'h0;
	logic ext = 1'b0, btn = 1'b0, flt = 1'b0, ack, blk, ls, lt, hs, ht;
	logic ra, rb, rc, rdy, re, ly, lr, hy, hr, p1, p2, p3, cl, ifi, irq;
	logic [3:0] knob;
	logic [15:0] dval;
	logic [7:0] routes [9] = '{8'h00, 8'hff, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
	logic [3:0] items [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc};
	int n_fail = 0, checks_done = 0;
	ocr_routing #(.KNOBS(4)) dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .low_start(ls), .low_trip(lt), .high_start(hs), .high_trip(ht),
		.block_to_module(blk), .fault_detect(flt), .fault_code_in(code),
		.external_block_input(ext), .reset_button(btn), .characteristic_switches(sw),
		.relay_a(ra), .relay_b(rb), .relay_c(rc), .relay_d(rdy), .relay_e(re),
		.low_yellow(ly), .low_red(lr), .high_yellow(hy), .high_red(hr),
		.phase_one_select_lamp(p1), .phase_two_select_lamp(p2), .phase_three_select_lamp(p3),
		.knob_lamp(knob), .characteristic_lamp(cl), .internal_fault_indicator(ifi),
		.display_value(dval), .irq(irq));
	ocr_meas_model meas (.cmd(cmd), .block_to_module(blk), .low_start(ls), .low_trip(lt),
		.high_start(hs), .high_trip(ht));
	initial begin
		forever #2.5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int waits = 0;
		@(posedge clk);
		{cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'hf, d};
		// ack ends the wait, the watchdog only a hung one; the count is checked afterwards
		do begin
			@(posedge clk);
			waits++;
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk(waits, 32'h2);
	endtask : wb
	task automatic drive(input logic [3:0] c, input int n);
		@(posedge clk);
		cmd <= c;
		repeat (n) @(posedge clk);
		#1;
	endtask : drive
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	function automatic logic [7:0] exp_out(input logic [7:0] r, input logic [3:0] c);
		logic l_s, l_t, h_s, h_t;
		{h_t, h_s, l_t, l_s} = c;
		exp_out = {(r[1] & h_s) | (r[2] & l_s) | (r[3] & h_t), (r[4] & h_t) | (r[6] & l_t),
			h_t | (r[7] & l_t), l_t | (r[5] & h_t), h_t, h_s & ~h_t, l_t, l_s & ~l_t};
	endfunction : exp_out
	initial begin
		#50000;
		n_fail++;
		wrap_up();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		wb(1'b0, OCR_ROUTE_OFS, 32'h0);
		chk(rd, 32'hff);
		wb(1'b0, OCR_OPTION_OFS, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, OCR_IRQ_MASK_OFS, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0);
		foreach (routes[i]) begin
			wb(1'b1, OCR_ROUTE_OFS, {24'h0, routes[i]});
			for (int c = 0; c < 16; c++) begin
				drive(c[3:0], 2);
				chk({rdy, rc, rb, ra, hr, hy, lr, ly}, exp_out(routes[i], c[3:0]));
			end
		end
		// blocking passes only through switch one
		@(posedge clk) ext <= 1'b1;
		drive(4'h2, 2);
		chk({blk, ra}, 2'h1);
		wb(1'b1, OCR_ROUTE_OFS, 32'hff);
		drive(4'h2, 2);
		chk({blk, ra}, 2'h2);
		wb(1'b1, OCR_ROUTE_OFS, 32'hfe);
		drive(4'h2, 2);
		chk({blk, ra}, 2'h1);
		@(posedge clk) ext <= 1'b0;
		drive(4'h0, 2);
		wb(1'b1, OCR_OPTION_OFS, 32'h1);
		drive(4'h2, 1);
		drive(4'h0, 3);
		chk({ra, lr}, 2'h3);
		drive(4'h8, 2);
		chk({rb, hr}, 2'h3);
		drive(4'h0, 2);
		@(posedge clk) btn <= 1'b1;
		drive(4'h0, 3);
		chk({ra, lr, rb, hr}, 4'h0);
		@(posedge clk) btn <= 1'b0;
		wb(1'b1, OCR_OPTION_OFS, 32'h0);
		drive(4'h2, 1);
		drive(4'h0, 2);
		chk({ra, lr}, 2'h0);
		wb(1'b1, OCR_IRQ_STATUS_OFS, 32'h1f);
		wb(1'b1, OCR_IRQ_MASK_OFS, 32'h02);
		drive(4'h2, 1);
		drive(4'h0, 1);
		chk(irq, 1'b1);
		wb(1'b0, OCR_IRQ_STATUS_OFS, 32'h0);
		chk(rd, 32'h02);
		wb(1'b1, OCR_IRQ_STATUS_OFS, 32'h02);
		drive(4'h0, 1);
		chk(irq, 1'b0);
		wb(1'b1, OCR_IRQ_MASK_OFS, 32'h0);
		drive(4'h2, 1);
		drive(4'h0, 1);
		chk(irq, 1'b0);
		foreach (items[i]) begin
			wb(1'b1, OCR_DISPLAY_OFS, {28'h0, items[i]});
			drive(4'h0, 2);
			chk({cl, knob, p3, p2, p1}, (items[i] == 4'hc) ? 8'h80 : 8'h1 << (items[i] - 1));
		end
		chk(dval, 16'h005a);
		@(posedge clk) flt <= 1'b1;
		drive(4'h0, 2);
		@(posedge clk) flt <= 1'b0;
		drive(4'h0, 2);
		chk({re, ifi, dval}, 18'h3003c);
		wb(1'b0, OCR_FAULT_CODE_OFS, 32'h0);
		chk(rd, 32'h3c);
		// live view: relay e and fault held, all else idle
		wb(1'b0, OCR_LIVE_OFS, 32'h0);
		chk(rd, 32'h820);
		wrap_up();
	end
endmodule : ocr_routing_bench
bind ocr_routing ocr_routing_assertions #(.KNOBS(KNOBS)) u_chk (.*);
